/* File: tb.sv */
// self-checking bench for the windowed watchdog
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import wdg_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp, irq, system_reset;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        nv_lock = 1'b0;
   logic        nv_en   = 1'b0;
   logic        nv_wen  = 1'b0;
   logic [11:0] nv_code = 12'h233;
   logic [7:0]  rd;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          w, c;
   // {write, index, write data, expected read}
   logic [27:0] rows [22] = '{
      28'h0_00_00_00, 28'h0_01_00_23, 28'h0_02_00_03, 28'h0_05_00_00, 28'h0_06_00_00,
      28'h0_07_00_00, 28'h0_08_00_00, 28'h1_03_a5_00, 28'h0_03_00_00, 28'h1_0c_5a_00,
      28'h0_0c_00_00, 28'h1_00_04_00, 28'h0_00_00_04, 28'h1_01_41_00, 28'h0_01_00_41,
      28'h1_01_23_00, 28'h1_05_01_00, 28'h1_05_00_00, 28'h0_05_00_01, 28'h0_04_00_01,
      28'h1_04_01_00, 28'h0_05_00_00};

   initial forever #2.5 ref_clk = ~ref_clk;

   wdg_top uut (
      .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .nvm_lock(nv_lock), .nvm_window_en(nv_wen),
      .nvm_enable(nv_en), .nvm_timeout_code(nv_code[7:4]), .nvm_window_code(nv_code[11:8]),
      .nvm_warning_code(nv_code[3:0]), .irq(irq), .system_reset(system_reset));
   wdg_host host (
      .ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic run(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : run

   task automatic acc(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
      host.xfer(wr, idx, wd, rd, w);
      if (w < 0) begin
         n_mismatch++;
         end_of_test();
      end
   endtask : acc

   task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
      acc(1'b0, idx, 8'h00);
      check({24'h0, rd}, {24'h0, exp});
   endtask : rdc

   // waits for irq (sel high) or system reset; cycles counted in c
   task automatic rise(input logic sel, input int lim);
      c = 0;
      do begin
         @(posedge ref_clk);
         c++;
      end while ((sel ? irq : system_reset) !== 1'b1 && c < lim);
      if (c >= lim) begin
         n_mismatch++;
         end_of_test();
      end
   endtask : rise

   initial begin
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      run(4);
      foreach (rows[i]) begin
         acc(rows[i][24], rows[i][21:16], rows[i][15:8]);
         if (!rows[i][24]) check({24'h0, rd}, {24'h0, rows[i][7:0]});
      end
      // transfer busy and stall of a second synchronised write
      acc(1'b1, WDG_IDX_CTRL, 8'h00);
      rdc(WDG_IDX_STATUS, 8'h80);
      run(4);
      rdc(WDG_IDX_STATUS, 8'h00);
      acc(1'b1, WDG_IDX_CTRL, 8'h04);
      acc(1'b1, WDG_IDX_CTRL, 8'h00);
      check(w > 0, 1);
      rdc(WDG_IDX_CTRL, 8'h00);
      // warning offset equal to period: reset comes, warning never
      acc(1'b1, WDG_IDX_FLAGS, 8'hff);
      acc(1'b1, WDG_IDX_CTRL, 8'h02);
      rdc(WDG_IDX_CTRL, 8'h02);
      acc(1'b1, WDG_IDX_CONFIG, 8'h00);
      rdc(WDG_IDX_CONFIG, 8'h23);
      acc(1'b1, WDG_IDX_CTRL, 8'h06);
      rdc(WDG_IDX_CTRL, 8'h02);
      rise(1'b0, 100);
      rdc(WDG_IDX_FLAGS, 8'h02);
      // normal mode warning and interrupt line
      acc(1'b1, WDG_IDX_CTRL, 8'h00);
      run(6);
      acc(1'b1, WDG_IDX_EWOFF, 8'h01);
      acc(1'b1, WDG_IDX_FLAGS, 8'hff);
      acc(1'b1, WDG_IDX_ENSET, 8'h01);
      acc(1'b1, WDG_IDX_CTRL, 8'h02);
      rise(1'b1, 40);
      check(c inside {[16:30]}, 1);
      rdc(WDG_IDX_FLAGS, 8'h03);
      acc(1'b1, WDG_IDX_ENCLR, 8'h01);
      run(2);
      check(irq, 0);
      acc(1'b1, WDG_IDX_ENSET, 8'h01);
      run(2);
      check(irq, 1);
      acc(1'b1, WDG_IDX_FLAGS, 8'h01);
      run(2);
      check(irq, 0);
      acc(1'b1, WDG_IDX_KEY, WDG_SERVICE_KEY);
      rise(1'b0, 90);
      check(c inside {[64:76]}, 1);
      // window mode: warning at open window, service in closed window
      acc(1'b1, WDG_IDX_CTRL, 8'h00);
      run(6);
      acc(1'b1, WDG_IDX_CTRL, 8'h04);
      acc(1'b1, WDG_IDX_FLAGS, 8'hff);
      acc(1'b1, WDG_IDX_CTRL, 8'h06);
      rise(1'b1, 60);
      check(c inside {[32:46]}, 1);
      acc(1'b1, WDG_IDX_KEY, WDG_SERVICE_KEY);
      acc(1'b1, WDG_IDX_KEY, WDG_SERVICE_KEY);
      rise(1'b0, 20);
      check(c inside {[1:12]}, 1);
      // permanent run lock
      acc(1'b1, WDG_IDX_CTRL, 8'h86);
      acc(1'b1, WDG_IDX_CONFIG, 8'h00);
      rdc(WDG_IDX_CONFIG, 8'h23);
      acc(1'b1, WDG_IDX_EWOFF, 8'h00);
      rdc(WDG_IDX_EWOFF, 8'h01);
      acc(1'b1, WDG_IDX_CTRL, 8'h00);
      rdc(WDG_IDX_CTRL, 8'h82);
      acc(1'b1, WDG_IDX_KEY, 8'h5a);
      rise(1'b0, 20);
      check(c inside {[1:12]}, 1);
      // power-on reset clears the lock and reloads startup values
      nv_wen  <= 1'b1;
      nv_code <= 12'h456;
      reset_n <= 1'b0;
      run(5);
      reset_n <= 1'b1;
      run(4);
      check(irq, 0);
      rdc(WDG_IDX_CTRL, 8'h04);
      rdc(WDG_IDX_CONFIG, 8'h45);
      rdc(WDG_IDX_EWOFF, 8'h06);
      // transfer-done flag drives the shared line
      acc(1'b1, WDG_IDX_ENSET, 8'h02);
      acc(1'b1, WDG_IDX_CTRL, 8'h04);
      rise(1'b1, 20);
      check(c inside {[1:8]}, 1);
      acc(1'b1, WDG_IDX_FLAGS, 8'h02);
      run(2);
      check(irq, 0);
      end_of_test();
   end
endmodule : tb

/* File: wdg_chk.sv */
// assertion checker on the watchdog top-level ports
module wdg_chk (
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        irq,
   input wire logic        system_reset
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       take;
   logic       rd_dp;
   logic       wr_dp;
   logic [5:0] idx;
   assign take = hsel && hready && htrans[1];
   // tracks the data phase that follows each taken address phase
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_dp <= 1'b0;
         wr_dp <= 1'b0;
         idx   <= 6'h00;
      end else if (take) begin
         rd_dp <= !hwrite;
         wr_dp <= hwrite;
         idx   <= haddr[7:2];
      end else if (hreadyout) begin
         rd_dp <= 1'b0;
         wr_dp <= 1'b0;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_okay_resp: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_plain_write: assert property (take && hwrite && haddr[7:2] != 6'h00 && haddr[7:2] != 6'h08
                                   |=> hreadyout)
      else $error("unsynchronised write stalled");
   a_sync_stall: assert property (take && hwrite && (haddr[7:2] == 6'h00 || haddr[7:2] == 6'h08)
                                  |=> ##[0:8] hreadyout)
      else $error("synchronised write stalled too long");
   a_reset_pulse: assert property ($rose(system_reset) |=> !system_reset)
      else $error("system reset longer than one cycle");
   a_bad_key: assert property (take && hwrite && haddr[7:2] == 6'h08 ##1 hwdata[7:0] != 8'ha5
                               |-> ##[1:16] system_reset)
      else $error("wrong key gave no system reset");
   a_irq_hold: assert property ($fell(irq) |-> $past(wr_dp) || $past(wr_dp, 2) || $past(wr_dp, 3))
      else $error("interrupt dropped without a write");
   a_rdata_high: assert property (rd_dp && hreadyout |-> hrdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_ctrl_rsvd: assert property (rd_dp && hreadyout && idx == 6'h00
                                 |-> hrdata[6:3] == 4'h0 && !hrdata[0])
      else $error("reserved control bits not zero");
   a_unmapped: assert property (rd_dp && hreadyout && (idx == 6'h03 || idx >= 6'h08)
                                |-> hrdata == 32'h0)
      else $error("unmapped or write-only read not zero");
endmodule : wdg_chk

bind wdg_top wdg_chk chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .irq(irq), .system_reset(system_reset)
);

/* File: wdg_count.sv */
// countdown core: period counter, closed/open window, warning and reset
module wdg_count (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       window_en,
   input  wire logic [3:0] timeout_code,
   input  wire logic [3:0] window_code,
   input  wire logic [3:0] warning_code,
   input  wire logic       service_ok,
   input  wire logic       service_bad,
   output logic            early_warning,
   output logic            system_reset
);
   import wdg_pkg::*;

   wdg_state_t        state;
   logic [14:0]       cnt;
   logic [14:0]       per_cyc;
   logic [14:0]       win_cyc;
   logic [14:0]       warn_cyc;
   logic              closed_end;
   logic              open_end;
   logic              warn_hit;

   always_comb begin
      per_cyc    = wdg_code_cycles(timeout_code);                        // R25
      win_cyc    = wdg_code_cycles(window_code);                         // R25
      warn_cyc   = wdg_code_cycles(warning_code);                        // R25
      closed_end = (state == WDG_CLOSED) && (cnt == win_cyc - 15'h0001);
      open_end   = (state == WDG_OPEN) && (cnt == per_cyc - 15'h0001);
      warn_hit   = (state == WDG_OPEN) && !window_en && (warn_cyc < per_cyc)
                   && (cnt == warn_cyc - 15'h0001);                      // R5 R6
   end

   // period counter, restarted on enable and on every good service
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= WDG_IDLE;
         cnt   <= 15'h0000;
      end else if (!run) begin
         state <= WDG_IDLE;
         cnt   <= 15'h0000;
      end else begin
         unique case (state)
            WDG_IDLE: begin
               state <= window_en ? WDG_CLOSED : WDG_OPEN;               // R17 R26
               cnt   <= 15'h0000;
            end
            WDG_CLOSED: begin
               if (service_ok || service_bad) begin
                  cnt <= 15'h0000;
               end else if (closed_end) begin
                  state <= WDG_OPEN;
                  cnt   <= 15'h0000;
               end else begin
                  cnt <= cnt + 15'h0001;
               end
            end
            WDG_OPEN: begin
               if (service_ok || service_bad || open_end) begin
                  state <= window_en ? WDG_CLOSED : WDG_OPEN;            // R26
                  cnt   <= 15'h0000;
               end else begin
                  cnt <= cnt + 15'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         early_warning <= 1'b0;
      end else begin
         early_warning <= run && !service_ok && !service_bad
                          && (closed_end || warn_hit);                   // R5 R7
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         system_reset <= 1'b0;
      end else begin
         system_reset <= service_bad                                     // R22
                         || (run && service_ok && state == WDG_CLOSED)   // R24
                         || (run && !service_ok && open_end);            // R23 R6
      end
   end

endmodule : wdg_count

/* File: wdg_host.sv */
// bus master model standing in for the processor side
module wdg_host (
   input  wire logic        ref_clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end
   // single word transfer; waits is -1 when the slave never answers
   task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output int waits);
      int n;
      hsel   <= 1'b1;
      haddr  <= {24'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      hwdata <= ~hwdata;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      waits = 0;
      do begin
         @(posedge ref_clk);
         waits++;
      end while (hready !== 1'b1 && waits < 100);
      rd = hrdata[7:0];
      waits = (n >= 100 || waits >= 100) ? -1 : waits - 1;
   endtask : xfer
endmodule : wdg_host

/* File: wdg_pkg.sv */
// shared constants, types and helpers of the windowed watchdog
package wdg_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] WDG_IDX_CTRL    = 6'h00;
   localparam logic [5:0] WDG_IDX_CONFIG  = 6'h01;
   localparam logic [5:0] WDG_IDX_EWOFF   = 6'h02;
   localparam logic [5:0] WDG_IDX_ENCLR   = 6'h04;
   localparam logic [5:0] WDG_IDX_ENSET   = 6'h05;
   localparam logic [5:0] WDG_IDX_FLAGS   = 6'h06;
   localparam logic [5:0] WDG_IDX_STATUS  = 6'h07;
   localparam logic [5:0] WDG_IDX_KEY     = 6'h08;

   // field positions
   localparam int WDG_CTRL_LOCK_BIT   = 7;
   localparam int WDG_CTRL_WEN_BIT    = 2;
   localparam int WDG_CTRL_EN_BIT     = 1;
   localparam int WDG_IRQ_EW_BIT      = 0;
   localparam int WDG_IRQ_DONE_BIT    = 1;
   localparam int WDG_STATUS_BUSY_BIT = 7;

   // reset values and codes
   localparam logic [7:0]  WDG_REG_RESET   = 8'h00;
   localparam logic [3:0]  WDG_CODE_RESET  = 4'h0;
   localparam logic [7:0]  WDG_SERVICE_KEY = 8'ha5;
   localparam logic [3:0]  WDG_CODE_MAX    = 4'hb;
   localparam int          WDG_CNT_W       = 15;
   localparam logic [14:0] WDG_BASE_CYCLES = 15'h0008;

   // bus-to-countdown transfer time in clock cycles
   localparam logic [1:0]  WDG_SYNC_CYCLES = 2'h3;

   typedef enum logic [1:0] {
      WDG_IDLE   = 2'b00,
      WDG_CLOSED = 2'b01,
      WDG_OPEN   = 2'b11
   } wdg_state_t;

   // period length of a 4-bit code; reserved codes act as the longest
   function automatic logic [14:0] wdg_code_cycles(input logic [3:0] code);
      logic [3:0] c;
      c = (code > WDG_CODE_MAX) ? WDG_CODE_MAX : code;
      return WDG_BASE_CYCLES << c;
   endfunction : wdg_code_cycles

endpackage : wdg_pkg

/* File: wdg_top.sv */
// windowed watchdog: AHB-Lite register slave, transfer handshake, interrupt
//
// Behaviour
// R1: early-warning flag sets on every warning event, enabled or not.
// R2: one to enable-set enables, one to enable-clear disables; zeros ignored.
// R3: interrupt line high while any flag is set and enabled.
// R4: one shared interrupt line; software reads flags to find the cause.
// R5: normal mode warns after the offset-code cycles from period start.
// R6: offset not shorter than period means reset first, never a warning.
// R7: window mode warns when the closed window ends, offset ignored.
// R8: busy bit sets at once on synchronised writes, clears when transferred.
// R9: transfer-done flag sets when a pending transfer finishes.
// R10: synchronised write while busy stalls the bus, then completes intact.
// R11: control and service-key writes pass through the transfer handshake.
// R12: byte, half-word and word accesses are all accepted.
// R13: protected registers take writes only while the watchdog is disabled.
// R14: permanent-run lock sets by writing one; only power-on reset clears it.
// R15: lock set blocks writes to timeout, warning offset and enable.
// R16: window-enable writable only while disabled or locked.
// R17: window-enable low selects normal mode, high selects window mode.
// R18: enable bit starts or stops the watchdog; writable only while unlocked.
// R19: written enable reads back at once; busy until the core follows.
// R20: reserved control bits read zero; software writes zero.
// R21: lock, window-enable and enable load from nonvolatile pins at startup.
// R22: key 0xa5 restarts the period; any other key resets the system.
// R23: unserviced period end issues a system reset.
// R24: service during the closed window issues a system reset.
// R25: code n selects eight shifted left n cycles, codes above 0xb reserved.
// R26: period counter restarts on enable and after every good service.
module wdg_top (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        nvm_lock,
   input  wire logic        nvm_window_en,
   input  wire logic        nvm_enable,
   input  wire logic [3:0]  nvm_timeout_code,
   input  wire logic [3:0]  nvm_window_code,
   input  wire logic [3:0]  nvm_warning_code,
   output logic             irq,
   output logic             system_reset
);
   import wdg_pkg::*;

   logic [1:0]  rst_pipe;
   logic        rst_n;
   logic        nvm_loaded;

   logic        dp_valid;
   logic        dp_write;
   logic        dp_lane0;
   logic [5:0]  dp_idx;
   logic        addr_take;
   logic        write_do;
   logic [7:0]  wdata;
   logic [7:0]  read_val;
   logic [7:0]  ctrl_rd;
   logic [7:0]  status_rd;

   logic        permanent_run_lock;
   logic        window_en;
   logic        enable;
   logic [3:0]  timeout_code;
   logic [3:0]  window_code;
   logic [3:0]  warning_delay_code;
   logic        irq_en_ew;
   logic        irq_en_done;
   logic        flag_ew;
   logic        flag_done;

   logic        domain_transfer_busy;
   logic        next_busy;
   logic [1:0]  sync_cnt;
   logic        sync_start;
   logic        sync_done;
   logic        pend_key;
   logic [7:0]  key_val;
   logic        core_run;
   logic        core_wen;
   logic        service_ok;
   logic        service_bad;
   logic        early_warning;

   logic        wr_ctrl;
   logic        wr_config;
   logic        wr_ewoff;
   logic        wr_enset;
   logic        wr_enclr;
   logic        wr_flags;

   // control and key writes pass through the transfer handshake
   function automatic logic sync_reg(input logic [5:0] idx);
      return (idx == WDG_IDX_CTRL) || (idx == WDG_IDX_KEY);
   endfunction : sync_reg

   // enable and flag registers share one bit layout
   function automatic logic [7:0] irq_bits(input logic ew, input logic done);
      logic [7:0] v;
      v                   = 8'h00;
      v[WDG_IRQ_EW_BIT]   = ew;
      v[WDG_IRQ_DONE_BIT] = done;
      return v;
   endfunction : irq_bits

   // reset release through two flip-flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // ---------------- AHB-Lite slave ----------------
   assign addr_take = hsel && hready && htrans[1];
   assign write_do  = dp_valid && dp_write && dp_lane0 && hreadyout;
   assign wdata     = hwdata[7:0];

   // register byte sits in lane 0; any access size that covers lane 0 hits it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_lane0 <= 1'b0;
         dp_idx   <= 6'h00;
      end else if (hready) begin
         dp_valid <= addr_take;
         dp_write <= hwrite;
         dp_lane0 <= (haddr[1:0] == 2'b00);                                // R12
         dp_idx   <= haddr[7:2];
      end
   end

   // reads take one wait state; synchronised writes wait while busy
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
      end else if (addr_take) begin
         hreadyout <= hwrite && !(next_busy && (haddr[1:0] == 2'b00)
                      && sync_reg(haddr[7:2]));                            // R10
      end else if (!hreadyout) begin
         hreadyout <= dp_write ? !next_busy : 1'b1;                        // R10
      end
   end

   // reserved bits stay zero
   always_comb begin
      ctrl_rd                        = 8'h00;
      ctrl_rd[WDG_CTRL_LOCK_BIT]     = permanent_run_lock;
      ctrl_rd[WDG_CTRL_WEN_BIT]      = window_en;
      ctrl_rd[WDG_CTRL_EN_BIT]       = enable;
      status_rd                      = 8'h00;
      status_rd[WDG_STATUS_BUSY_BIT] = domain_transfer_busy;
   end

   always_comb begin
      unique case (dp_idx)
         WDG_IDX_CTRL:   read_val = ctrl_rd;                                // R19 R20
         WDG_IDX_CONFIG: read_val = {window_code, timeout_code};
         WDG_IDX_EWOFF:  read_val = {4'h0, warning_delay_code};
         WDG_IDX_ENCLR,
         WDG_IDX_ENSET:  read_val = irq_bits(irq_en_ew, irq_en_done);
         WDG_IDX_FLAGS:  read_val = irq_bits(flag_ew, flag_done);           // R4
         WDG_IDX_STATUS: read_val = status_rd;                              // R8
         default:        read_val = WDG_REG_RESET;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (dp_valid && !dp_write && !hreadyout) begin
         hrdata <= dp_lane0 ? {24'h00_0000, read_val} : 32'h0000_0000;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // ---------------- register writes ----------------
   assign wr_ctrl   = write_do && (dp_idx == WDG_IDX_CTRL);
   assign wr_config = write_do && (dp_idx == WDG_IDX_CONFIG);
   assign wr_ewoff  = write_do && (dp_idx == WDG_IDX_EWOFF);
   assign wr_enset  = write_do && (dp_idx == WDG_IDX_ENSET);
   assign wr_enclr  = write_do && (dp_idx == WDG_IDX_ENCLR);
   assign wr_flags  = write_do && (dp_idx == WDG_IDX_FLAGS);

   // startup values are caught once, one cycle after reset release
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nvm_loaded <= 1'b0;
      end else begin
         nvm_loaded <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         permanent_run_lock <= 1'b0;
         window_en          <= 1'b0;
         enable             <= 1'b0;
      end else if (!nvm_loaded) begin
         permanent_run_lock <= nvm_lock;                                    // R21
         window_en          <= nvm_window_en;                               // R21
         enable             <= nvm_enable;                                  // R21
      end else if (wr_ctrl) begin
         if (wdata[WDG_CTRL_LOCK_BIT]) begin
            permanent_run_lock <= 1'b1;                                     // R14
         end
         if (!permanent_run_lock) begin
            enable <= wdata[WDG_CTRL_EN_BIT];                               // R18 R15 R19
         end
         if (!enable || permanent_run_lock) begin
            window_en <= wdata[WDG_CTRL_WEN_BIT];                           // R16
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timeout_code       <= WDG_CODE_RESET;
         window_code        <= WDG_CODE_RESET;
         warning_delay_code <= WDG_CODE_RESET;
      end else if (!nvm_loaded) begin
         timeout_code       <= nvm_timeout_code;
         window_code        <= nvm_window_code;
         warning_delay_code <= nvm_warning_code;
      end else begin
         if (wr_config && !enable && !permanent_run_lock) begin             // R13 R15
            timeout_code <= wdata[3:0];
            window_code  <= wdata[7:4];
         end
         if (wr_ewoff && !enable && !permanent_run_lock) begin              // R13 R15
            warning_delay_code <= wdata[3:0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_ew   <= 1'b0;
         irq_en_done <= 1'b0;
      end else if (wr_enset) begin
         irq_en_ew   <= irq_en_ew | wdata[WDG_IRQ_EW_BIT];                  // R2
         irq_en_done <= irq_en_done | wdata[WDG_IRQ_DONE_BIT];              // R2
      end else if (wr_enclr) begin
         irq_en_ew   <= irq_en_ew & !wdata[WDG_IRQ_EW_BIT];                 // R2
         irq_en_done <= irq_en_done & !wdata[WDG_IRQ_DONE_BIT];             // R2
      end
   end

   // flags: a set in the clearing cycle wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ew   <= 1'b0;
         flag_done <= 1'b0;
      end else begin
         flag_ew   <= early_warning
                      || (flag_ew && !(wr_flags && wdata[WDG_IRQ_EW_BIT]));  // R1
         flag_done <= sync_done
                      || (flag_done && !(wr_flags && wdata[WDG_IRQ_DONE_BIT])); // R9
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (flag_ew && irq_en_ew) || (flag_done && irq_en_done);       // R3 R4
      end
   end

   // ---------------- transfer into the countdown ----------------
   assign sync_start = write_do && sync_reg(dp_idx);                        // R11
   assign sync_done  = domain_transfer_busy && (sync_cnt == WDG_SYNC_CYCLES - 2'h1);
   assign next_busy  = sync_start || (domain_transfer_busy && !sync_done);  // R8

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         domain_transfer_busy <= 1'b0;
         sync_cnt             <= 2'h0;
         pend_key             <= 1'b0;
         key_val              <= WDG_REG_RESET;
      end else begin
         domain_transfer_busy <= next_busy;                                 // R8
         sync_cnt             <= (sync_start || !domain_transfer_busy) ? 2'h0 : sync_cnt + 2'h1;
         if (sync_start) begin
            pend_key <= (dp_idx == WDG_IDX_KEY);
            key_val  <= wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_run <= 1'b0;
         core_wen <= 1'b0;
      end else if (!nvm_loaded) begin
         core_run <= nvm_enable || nvm_lock;
         core_wen <= nvm_window_en;
      end else if (sync_done && !pend_key) begin
         core_run <= enable || permanent_run_lock;                          // R14 R18
         core_wen <= window_en;                                             // R17
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         service_ok  <= 1'b0;
         service_bad <= 1'b0;
      end else begin
         service_ok  <= sync_done && pend_key && (key_val == WDG_SERVICE_KEY); // R22
         service_bad <= sync_done && pend_key && (key_val != WDG_SERVICE_KEY); // R22
      end
   end

   wdg_count u_count (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .run           (core_run),
      .window_en     (core_wen),
      .timeout_code  (timeout_code),
      .window_code   (window_code),
      .warning_code  (warning_delay_code),
      .service_ok    (service_ok),
      .service_bad   (service_bad),
      .early_warning (early_warning),
      .system_reset  (system_reset)
   );

endmodule : wdg_top
